// *** rtl/sdcm_top.sv ***
// Command decode and mode programming for a low-power SDRAM
// Overview of operation
// - Single-write bit makes writes one location
// - Bank bits choose standard or extended register
// - Extended register held until reprogrammed
// - Extended settings survive deep power-down
// - Temperature refresh field is ignored
// - Partial refresh picks one of five regions
// - Only chosen region refreshed in self refresh
// - Extended bits 5-6 set drive strength
// - Chip-select high inhibit; all-high strobes no-op
// - Row strobe alone decodes bank activate
// - Column strobe starts read or write burst
// - Address bit 10 selects auto precharge
// - Write strobe alone: burst stop or power-down
// - Row and write strobes decode precharge
// - Row and column strobes: auto or self refresh
// - All strobes low load mode register
// - Byte mask high blocks write and output
// - Standard register field layout
`timescale 1ns/1ps
`include "sdcm_cfg.svh"
module sdcm_top
  import sdcm_pkg::*;
(
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  // Command pins
  input  wire logic                     cs_n,
  input  wire logic                     ras_n,
  input  wire logic                     cas_n,
  input  wire logic                     we_n,
  input  wire logic                     cke,
  input  wire logic                     byte_mask,
  input  wire logic                     bank_select_bit0,
  input  wire logic                     bank_select_bit1,
  input  wire logic [`SDCM_ADDR_W-1:0]  addr,
  // Decoded command, one-cycle pulses
  output sdcm_cmd_e                     cmd_q,
  output logic                          cmd_valid_q,
  output logic [1:0]                    cmd_bank_q,
  output logic [`SDCM_ADDR_W-1:0]       cmd_row_q,
  output logic [`SDCM_COL_W-1:0]        cmd_col_q,
  output logic                          cmd_auto_pre_q,
  output logic                          cmd_pre_all_q,
  output logic [3:0]                    cmd_write_len_q,
  output logic [3:0]                    cmd_read_len_q,
  // Mask gating levels
  output logic                          write_en_q,
  output logic                          out_drive_en_q,
  // Standard mode settings
  output logic [2:0]                    burst_count_q,
  output logic                          burst_interleave_q,
  output logic [2:0]                    read_latency_q,
  output logic [1:0]                    op_mode_q,
  output logic                          write_burst_single_bit_q,
  // Extended mode settings
  output logic [`SDCM_ADDR_W-1:0]       extended_setup_register_q,
  output logic [1:0]                    drive_strength_q,
  output sdcm_par_e                     partial_array_refresh_q,
  output logic [3:0]                    refresh_bank_keep_q,
  output logic [1:0]                    refresh_row_top_zero_q,
  // Power state
  output logic                          self_refresh_q,
  output logic                          deep_powerdown_state_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Burst length in locations from the 3-bit code; 0 marks continuous page
  function automatic logic [3:0] burst_len(input logic [2:0] code);
    logic [3:0] len;
    len = 4'h0;
    unique case (code)
      3'h0: len = 4'h1;
      3'h1: len = 4'h2;
      3'h2: len = 4'h4;
      3'h3: len = 4'h8;
      default: len = 4'h0;
    endcase
    return len;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  sdcm_cmd_e  dec_cmd;
  sdcm_par_e  par_region;
  logic [3:0] par_bank_keep;
  logic [1:0] par_row_zero;

  sdcm_cmd_dec u_dec (
    .cs_n  (cs_n),
    .ras_n (ras_n),
    .cas_n (cas_n),
    .we_n  (we_n),
    .cke   (cke),
    .cmd   (dec_cmd)
  );

  // Bank pair steers load-mode target
  wire [1:0] bank_sel  = {bank_select_bit1, bank_select_bit0};
  wire       is_load   = (dec_cmd == SDCM_CMD_LOAD_MODE);
  wire       load_std  = is_load && (bank_sel == `SDCM_MS_STD);
  wire       load_ext  = is_load && (bank_sel == `SDCM_MS_EXT);
  wire       is_rw     = (dec_cmd == SDCM_CMD_READ) || (dec_cmd == SDCM_CMD_WRITE);
  wire       is_valid  = (dec_cmd != SDCM_CMD_INHIBIT) && (dec_cmd != SDCM_CMD_NOP);

  // Reserved bank codes on load are dropped, leaving both registers intact
  logic [`SDCM_ADDR_W-1:0] mode_q;
  logic [`SDCM_ADDR_W-1:0] mode_d;
  logic [`SDCM_ADDR_W-1:0] ext_d;
  assign mode_d = load_std ? addr : mode_q;
  // Only an extended load changes it; power-down is not a reset here
  assign ext_d  = load_ext ? addr : extended_setup_register_q;

  // Standard field view
  wire [2:0] bl_code  = mode_q[`SDCM_MR_BL_LSB +: 3];
  wire       wbs      = mode_q[`SDCM_MR_WBS_BIT];
  wire [3:0] rd_len   = burst_len(bl_code);
  wire [3:0] wr_len   = wbs ? 4'h1 : burst_len(bl_code);

  // Temperature field bits are stored but nothing reads them
  wire [2:0] par_code = ext_d[`SDCM_EM_PAR_LSB +: 3];

  sdcm_par_map u_par (
    .code         (par_code),
    .region       (par_region),
    .bank_keep    (par_bank_keep),
    .row_top_zero (par_row_zero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode storage

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_q                    <= `SDCM_MR_RESET;
      extended_setup_register_q <= `SDCM_EM_RESET;
    end else begin
      mode_q                    <= mode_d;
      extended_setup_register_q <= ext_d;
    end
  end

  // Field outputs registered off the next-state words, in step with the stores
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      burst_count_q            <= 3'h0;
      burst_interleave_q       <= 1'b0;
      read_latency_q           <= 3'h0;
      op_mode_q                <= 2'h0;
      write_burst_single_bit_q <= 1'b0;
      drive_strength_q         <= 2'h0;
      partial_array_refresh_q  <= SDCM_PAR_ALL;
      refresh_bank_keep_q      <= 4'hF;
      refresh_row_top_zero_q   <= 2'h0;
    end else begin
      burst_count_q            <= mode_d[`SDCM_MR_BL_LSB +: 3];
      burst_interleave_q       <= mode_d[`SDCM_MR_BT_BIT];
      read_latency_q           <= mode_d[`SDCM_MR_RL_LSB +: 3];
      op_mode_q                <= mode_d[`SDCM_MR_OP_LSB +: 2];
      write_burst_single_bit_q <= mode_d[`SDCM_MR_WBS_BIT];
      drive_strength_q         <= ext_d[`SDCM_EM_DS_LSB +: 2];
      partial_array_refresh_q  <= par_region;
      refresh_bank_keep_q      <= par_bank_keep;
      refresh_row_top_zero_q   <= par_row_zero;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command outputs

  // Registered one cycle after the pins, like the device's own pipeline
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmd_q           <= SDCM_CMD_INHIBIT;
      cmd_valid_q     <= 1'b0;
      cmd_bank_q      <= 2'h0;
      cmd_row_q       <= '0;
      cmd_col_q       <= '0;
      cmd_auto_pre_q  <= 1'b0;
      cmd_pre_all_q   <= 1'b0;
      cmd_write_len_q <= 4'h0;
      cmd_read_len_q  <= 4'h0;
    end else begin
      cmd_q           <= dec_cmd;
      cmd_valid_q     <= is_valid;
      cmd_bank_q      <= bank_sel;
      cmd_row_q       <= (dec_cmd == SDCM_CMD_ACTIVATE) ? addr : '0;
      cmd_col_q       <= is_rw ? addr[`SDCM_COL_W-1:0] : '0;
      cmd_auto_pre_q  <= is_rw && addr[`SDCM_AP_BIT];
      cmd_pre_all_q   <= (dec_cmd == SDCM_CMD_PRECHARGE) && addr[`SDCM_AP_BIT];
      cmd_write_len_q <= (dec_cmd == SDCM_CMD_WRITE) ? wr_len : 4'h0;
      cmd_read_len_q  <= (dec_cmd == SDCM_CMD_READ) ? rd_len : 4'h0;
    end
  end

  // Mask acts every cycle regardless of command
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      write_en_q     <= 1'b0;
      out_drive_en_q <= 1'b0;
    end else begin
      write_en_q     <= !byte_mask;
      out_drive_en_q <= !byte_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power states

  // Exit is taken as the clock gate returning high; exit timing is outside
  wire sr_d  = (dec_cmd == SDCM_CMD_SELF_REF) || (self_refresh_q && !cke);
  wire dpd_d = (dec_cmd == SDCM_CMD_DEEP_PD) || (deep_powerdown_state_q && !cke);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      self_refresh_q         <= 1'b0;
      deep_powerdown_state_q <= 1'b0;
    end else begin
      self_refresh_q         <= sr_d;
      deep_powerdown_state_q <= dpd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_ext_load;
    is_load && bank_sel == `SDCM_MS_EXT;
  endsequence

  sequence s_std_load;
    is_load && bank_sel == `SDCM_MS_STD;
  endsequence

  chk_ext_hold: assert property (@(posedge core_clk) disable iff (rst)
    !load_ext |=> $stable(extended_setup_register_q))
    else $error("extended register changed without load");

  chk_ext_load: assert property (@(posedge core_clk) disable iff (rst)
    s_ext_load |=> extended_setup_register_q == $past(addr))
    else $error("extended load not stored");

  chk_dpd_keep: assert property (@(posedge core_clk) disable iff (rst)
    deep_powerdown_state_q |-> $stable(extended_setup_register_q) || $past(load_ext))
    else $error("extended settings lost in power-down");

  chk_single_wr: assert property (@(posedge core_clk) disable iff (rst)
    (dec_cmd == SDCM_CMD_WRITE && wbs) |=> cmd_write_len_q == 4'h1)
    else $error("single write length wrong");

  chk_inhibit: assert property (@(posedge core_clk) disable iff (rst)
    cs_n |=> cmd_q == SDCM_CMD_INHIBIT && !cmd_valid_q)
    else $error("chip-select high not inhibit");

  chk_auto_pre: assert property (@(posedge core_clk) disable iff (rst)
    is_rw |=> cmd_auto_pre_q == $past(addr[`SDCM_AP_BIT]))
    else $error("auto precharge flag wrong");

  chk_mask_gate: assert property (@(posedge core_clk) disable iff (rst)
    byte_mask |=> !write_en_q && !out_drive_en_q)
    else $error("mask did not block");

  chk_stop_cke: assert property (@(posedge core_clk) disable iff (rst)
    (!cs_n && ras_n && cas_n && !we_n && !cke) |=> deep_powerdown_state_q)
    else $error("power-down entry missed");

  chk_self_ref: assert property (@(posedge core_clk) disable iff (rst)
    (!cs_n && !ras_n && !cas_n && we_n && !cke) |=> self_refresh_q ##1 (self_refresh_q || cke))
    else $error("self refresh entry missed");

  chk_drive_str: assert property (@(posedge core_clk) disable iff (rst)
    s_ext_load |=> drive_strength_q == $past(addr[6:5]))
    else $error("drive strength not applied");

  // Field, decode and power-state checks one cycle after the pins; the temperature check compares within one cycle
  chk_row_field: assert property (@(posedge core_clk) disable iff (rst)
    dec_cmd == SDCM_CMD_ACTIVATE |=> cmd_row_q == $past(addr) && cmd_bank_q == $past(bank_sel))
    else $error("activate row or bank wrong");

  chk_col_field: assert property (@(posedge core_clk) disable iff (rst)
    is_rw |=> cmd_col_q == $past(addr[`SDCM_COL_W-1:0]) && cmd_bank_q == $past(bank_sel))
    else $error("read or write column wrong");

  chk_pre_all: assert property (@(posedge core_clk) disable iff (rst)
    dec_cmd == SDCM_CMD_PRECHARGE |=> cmd_pre_all_q == $past(addr[`SDCM_AP_BIT]))
    else $error("precharge scope wrong");

  chk_nop_quiet: assert property (@(posedge core_clk) disable iff (rst)
    (!cs_n && ras_n && cas_n && we_n) |=> cmd_q == SDCM_CMD_NOP && !cmd_valid_q)
    else $error("no-op not decoded");

  chk_load_pins: assert property (@(posedge core_clk) disable iff (rst)
    (!cs_n && !ras_n && !cas_n && !we_n) |=> cmd_q == SDCM_CMD_LOAD_MODE && cmd_valid_q)
    else $error("load mode not decoded");

  chk_std_fields: assert property (@(posedge core_clk) disable iff (rst)
    s_std_load |=> burst_count_q == $past(addr[`SDCM_MR_BL_LSB +: 3])
      && read_latency_q == $past(addr[`SDCM_MR_RL_LSB +: 3]))
    else $error("standard fields not applied");

  chk_burst_wr: assert property (@(posedge core_clk) disable iff (rst)
    (dec_cmd == SDCM_CMD_WRITE && !wbs && bl_code == 3'h3) |=> cmd_write_len_q == 4'h8)
    else $error("write burst length wrong");

  chk_burst_rd: assert property (@(posedge core_clk) disable iff (rst)
    (dec_cmd == SDCM_CMD_READ && wbs && bl_code == 3'h3) |=> cmd_read_len_q == 4'h8)
    else $error("read burst length wrong");

  chk_mask_open: assert property (@(posedge core_clk) disable iff (rst)
    !byte_mask |=> write_en_q && out_drive_en_q)
    else $error("mask low did not enable");

  chk_burst_stop: assert property (@(posedge core_clk) disable iff (rst)
    (!cs_n && ras_n && cas_n && !we_n && cke) |=> cmd_q == SDCM_CMD_BURST_STOP
      && !deep_powerdown_state_q)
    else $error("burst stop not decoded");

  chk_auto_ref: assert property (@(posedge core_clk) disable iff (rst)
    (!cs_n && !ras_n && !cas_n && we_n && cke) |=> cmd_q == SDCM_CMD_AUTO_REF
      && !self_refresh_q)
    else $error("auto refresh not decoded");

  chk_temp_ignored: assert property (@(posedge core_clk) disable iff (rst)
    $stable(extended_setup_register_q[`SDCM_EM_DS_LSB +: 2])
      && $stable(extended_setup_register_q[`SDCM_EM_PAR_LSB +: 3])
      |-> $stable(drive_strength_q) && $stable(partial_array_refresh_q))
    else $error("temperature bits changed a setting");

  chk_dpd_exit: assert property (@(posedge core_clk) disable iff (rst)
    deep_powerdown_state_q && cke |=> !deep_powerdown_state_q)
    else $error("deep power-down not left");

  chk_sr_exit: assert property (@(posedge core_clk) disable iff (rst)
    self_refresh_q && cke |=> !self_refresh_q)
    else $error("self refresh not left");

  chk_region_one: assert property (@(posedge core_clk) disable iff (rst)
    s_ext_load ##0 (addr[`SDCM_EM_PAR_LSB +: 3] == 3'h2) |=> refresh_bank_keep_q == 4'h1
      && partial_array_refresh_q == SDCM_PAR_ONE)
    else $error("one-bank region wrong");

  chk_region_half: assert property (@(posedge core_clk) disable iff (rst)
    s_ext_load ##0 (addr[`SDCM_EM_PAR_LSB +: 3] == 3'h5) |=> refresh_row_top_zero_q == 2'h2
      && refresh_bank_keep_q == 4'h1)
    else $error("half-bank region wrong");

endmodule

// *** rtl/sdcm_cfg.svh ***
// Constants for the command and mode decode block
`ifndef SDCM_CFG_SVH
`define SDCM_CFG_SVH
`define SDCM_ADDR_W        13
`define SDCM_COL_W         10
`define SDCM_AP_BIT        10
`define SDCM_MR_BL_LSB     0
`define SDCM_MR_BT_BIT     3
`define SDCM_MR_RL_LSB     4
`define SDCM_MR_OP_LSB     7
`define SDCM_MR_WBS_BIT    9
`define SDCM_EM_PAR_LSB    0
`define SDCM_EM_TCR_LSB    3
`define SDCM_EM_DS_LSB     5
`define SDCM_MR_RESET      13'h0000
`define SDCM_EM_RESET      13'h0000
`define SDCM_MS_STD        2'h0
`define SDCM_MS_EXT        2'h2
`endif

// *** rtl/sdcm_pkg.sv ***
// Types shared by the command and mode decode block
package sdcm_pkg;
  typedef enum logic [3:0] {
    SDCM_CMD_INHIBIT, SDCM_CMD_NOP, SDCM_CMD_ACTIVATE, SDCM_CMD_READ,
    SDCM_CMD_WRITE, SDCM_CMD_BURST_STOP, SDCM_CMD_DEEP_PD, SDCM_CMD_PRECHARGE,
    SDCM_CMD_AUTO_REF, SDCM_CMD_SELF_REF, SDCM_CMD_LOAD_MODE
  } sdcm_cmd_e;
  typedef enum logic [2:0] {
    SDCM_PAR_ALL, SDCM_PAR_TWO, SDCM_PAR_ONE, SDCM_PAR_HALF, SDCM_PAR_QUARTER,
    SDCM_PAR_RSVD
  } sdcm_par_e;
endpackage

// *** rtl/sdcm_cmd_dec.sv ***
// Combinational pin-to-command decoder
`timescale 1ns/1ps
module sdcm_cmd_dec
  import sdcm_pkg::*;
(
  // Command pins
  input  wire logic      cs_n,
  input  wire logic      ras_n,
  input  wire logic      cas_n,
  input  wire logic      we_n,
  input  wire logic      cke,
  // Decoded command
  output sdcm_cmd_e      cmd
);
  // Inhibit dominates; cke splits the shared encodings
  always_comb begin
    cmd = SDCM_CMD_NOP;
    if (cs_n) begin
      cmd = SDCM_CMD_INHIBIT;
    end else begin
      unique case ({ras_n, cas_n, we_n})
        3'h7: cmd = SDCM_CMD_NOP;
        3'h3: cmd = SDCM_CMD_ACTIVATE;
        3'h5: cmd = SDCM_CMD_READ;
        3'h4: cmd = SDCM_CMD_WRITE;
        3'h6: cmd = cke ? SDCM_CMD_BURST_STOP : SDCM_CMD_DEEP_PD;
        3'h2: cmd = SDCM_CMD_PRECHARGE;
        3'h1: cmd = cke ? SDCM_CMD_AUTO_REF : SDCM_CMD_SELF_REF;
        3'h0: cmd = SDCM_CMD_LOAD_MODE;
        default: cmd = SDCM_CMD_NOP;
      endcase
    end
  end
endmodule

// *** rtl/sdcm_par_map.sv ***
// Maps partial-array refresh code to region enables
`timescale 1ns/1ps
module sdcm_par_map
  import sdcm_pkg::*;
(
  // Field in
  input  wire logic [2:0] code,
  // Region out
  output sdcm_par_e       region,
  output logic [3:0]      bank_keep,
  output logic [1:0]      row_top_zero
);
  // Five legal regions; unused codes report the reserved region with all banks kept
  always_comb begin
    region       = SDCM_PAR_ALL;
    bank_keep    = 4'hF;
    row_top_zero = 2'h0;
    unique case (code)
      3'h0: begin region = SDCM_PAR_ALL; end
      3'h1: begin region = SDCM_PAR_TWO; bank_keep = 4'h3; end
      3'h2: begin region = SDCM_PAR_ONE; bank_keep = 4'h1; end
      3'h5: begin
        region       = SDCM_PAR_HALF;
        bank_keep    = 4'h1;
        row_top_zero = 2'h2;
      end
      3'h6: begin
        region       = SDCM_PAR_QUARTER;
        bank_keep    = 4'h1;
        row_top_zero = 2'h3;
      end
      default: begin region = SDCM_PAR_RSVD; end
    endcase
  end
endmodule

// *** dv/sdcm_ctrl_model.sv ***
// Behavioural memory-controller model that drives the command pins
`timescale 1ns/1ps
module sdcm_ctrl_model (
  // Clock
  input  wire logic        core_clk,
  // Command pins toward the device
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic             cke,
  output logic             byte_mask,
  output logic             bank_select_bit0,
  output logic             bank_select_bit1,
  output logic [12:0]      addr
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle pins are a selected no-op with the clock gate high
  initial begin
    {cs_n, ras_n, cas_n, we_n, cke} = 5'h0F;
    byte_mask = 1'b0;
    {bank_select_bit1, bank_select_bit0} = 2'h0;
    addr = 13'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One command cycle, then back to no-op; outputs settled on return
  // Address flips after the command so stale values never look held
  task automatic send(input logic [4:0] pins, input logic [1:0] bank,
                      input logic [12:0] a, input logic mask);
    @(posedge core_clk);
    {cs_n, ras_n, cas_n, we_n, cke} <= pins;
    {bank_select_bit1, bank_select_bit0} <= bank;
    addr <= a;
    byte_mask <= mask;
    @(posedge core_clk);
    {cs_n, ras_n, cas_n, we_n, cke} <= 5'h0F;
    addr <= ~a;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Extended load: bursts drained and banks closed first, upper op-code bits zero
  task automatic load_ext(input logic [1:0] bank, input logic [6:0] op);
    repeat (8) @(posedge core_clk);       // Longest burst has ended
    send(5'h05, 2'h0, 13'h0400, 1'b0);    // Close every bank
    send(5'h01, bank, {6'h00, op}, 1'b0);
    repeat (2) @(posedge core_clk);       // Settle before the next command
    #1;
  endtask
endmodule

// *** dv/tb_sdcm_command_mode_decode.sv ***
// Self-checking testbench for the command and mode decode block
`timescale 1ns/1ps
module tb_sdcm_command_mode_decode
  import sdcm_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, ras_n, cas_n, we_n, cke, byte_mask, bank_select_bit0, bank_select_bit1;
  logic [12:0] addr, cmd_row_q, extended_setup_register_q;
  sdcm_cmd_e cmd_q;
  sdcm_par_e partial_array_refresh_q;
  logic cmd_valid_q, cmd_auto_pre_q, cmd_pre_all_q, write_en_q, out_drive_en_q;
  logic write_burst_single_bit_q, self_refresh_q, deep_powerdown_state_q;
  logic burst_interleave_q;
  logic [1:0] cmd_bank_q, drive_strength_q, op_mode_q, refresh_row_top_zero_q;
  logic [9:0] cmd_col_q;
  logic [3:0] cmd_write_len_q, cmd_read_len_q, refresh_bank_keep_q;
  logic [2:0] burst_count_q, read_latency_q;
  int bad_count = 0;
  int checked = 0;

  ////////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  always #2.5 core_clk = ~core_clk;

  sdcm_ctrl_model ctrl_u (.core_clk, .cs_n, .ras_n, .cas_n, .we_n, .cke, .byte_mask,
    .bank_select_bit0, .bank_select_bit1, .addr);

  sdcm_top dut_u (.core_clk, .rst, .cs_n, .ras_n, .cas_n, .we_n, .cke, .byte_mask,
    .bank_select_bit0, .bank_select_bit1, .addr, .cmd_q, .cmd_valid_q, .cmd_bank_q,
    .cmd_row_q, .cmd_col_q, .cmd_auto_pre_q, .cmd_pre_all_q, .cmd_write_len_q,
    .cmd_read_len_q, .write_en_q, .out_drive_en_q, .burst_count_q,
    .burst_interleave_q, .read_latency_q, .op_mode_q, .write_burst_single_bit_q,
    .extended_setup_register_q, .drive_strength_q, .partial_array_refresh_q,
    .refresh_bank_keep_q, .refresh_row_top_zero_q, .self_refresh_q,
    .deep_powerdown_state_q);

  ////////////////////////////////////////////////////////////////////////////
  // Comparison and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Values left by reset, looked at before the first edge after release
  task automatic t_reset();
    #1;
    check(cmd_q, SDCM_CMD_INHIBIT);
    check(cmd_valid_q, 1'b0);
    check(partial_array_refresh_q, SDCM_PAR_ALL);
    check(refresh_bank_keep_q, 4'hF);
    check(extended_setup_register_q, 13'h0000);
    $display("reset test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One pin pattern per command; inhibit has all strobes low so chip-select must win
  // Burst stop follows a write with auto precharge off
  task automatic t_decode();
    logic [4:0] pins [11] = '{5'h11, 5'h0F, 5'h07, 5'h0B, 5'h09, 5'h0D, 5'h0C,
                              5'h05, 5'h03, 5'h02, 5'h01};
    sdcm_cmd_e exp [11] = '{SDCM_CMD_INHIBIT, SDCM_CMD_NOP, SDCM_CMD_ACTIVATE,
      SDCM_CMD_READ, SDCM_CMD_WRITE, SDCM_CMD_BURST_STOP, SDCM_CMD_DEEP_PD,
      SDCM_CMD_PRECHARGE, SDCM_CMD_AUTO_REF, SDCM_CMD_SELF_REF, SDCM_CMD_LOAD_MODE};
    for (int i = 0; i < 11; i++) begin
      ctrl_u.send(pins[i], 2'h0, 13'h0000, 1'b0);
      check(cmd_q, exp[i]);
      check(cmd_valid_q, i > 1);
      if (i == 9) check(self_refresh_q, 1'b1);
    end
    $display("decode test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Bank, row, column and address bit 10 at field boundaries
  task automatic t_fields();
    ctrl_u.send(5'h07, 2'h2, 13'h1ABC, 1'b0);
    check(cmd_bank_q, 2'h2);
    check(cmd_row_q, 13'h1ABC);
    ctrl_u.send(5'h0B, 2'h1, 13'h07FF, 1'b0);
    check(cmd_col_q, 10'h3FF);
    check(cmd_auto_pre_q, 1'b1);
    ctrl_u.send(5'h09, 2'h3, 13'h03FF, 1'b0);
    check(cmd_bank_q, 2'h3);
    check(cmd_auto_pre_q, 1'b0);
    ctrl_u.send(5'h05, 2'h1, 13'h0400, 1'b0);
    check(cmd_pre_all_q, 1'b1);
    ctrl_u.send(5'h05, 2'h1, 13'h0000, 1'b0);
    check(cmd_pre_all_q, 1'b0);
    $display("field test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Standard register layout and the single-location write mode
  task automatic t_std_mode();
    ctrl_u.send(5'h01, 2'h0, 13'h0233, 1'b0);
    check(burst_count_q, 3'h3);
    check(read_latency_q, 3'h3);
    check(write_burst_single_bit_q, 1'b1);
    check(burst_interleave_q, 1'b0);
    check(op_mode_q, 2'h0);
    ctrl_u.send(5'h09, 2'h0, 13'h0000, 1'b0);
    check(cmd_write_len_q, 4'h1);
    ctrl_u.send(5'h0B, 2'h0, 13'h0000, 1'b0);
    check(cmd_read_len_q, 4'h8);
    ctrl_u.send(5'h01, 2'h0, 13'h003B, 1'b0);
    check(burst_interleave_q, 1'b1);
    ctrl_u.send(5'h09, 2'h0, 13'h0000, 1'b0);
    check(cmd_write_len_q, 4'h8);
    $display("standard mode test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Refresh regions, drive strength, ignored temperature bits, retention
  task automatic t_ext_mode();
    logic [2:0] code [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
    sdcm_par_e reg_e [5] = '{SDCM_PAR_ALL, SDCM_PAR_TWO, SDCM_PAR_ONE, SDCM_PAR_HALF,
                             SDCM_PAR_QUARTER};
    logic [3:0] keep [5] = '{4'hF, 4'h3, 4'h1, 4'h1, 4'h1};
    logic [1:0] row0 [5] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h3};
    logic [6:0] op;
    for (int i = 0; i < 5; i++) begin
      op = {i[1:0], i[1:0], code[i]};
      ctrl_u.load_ext(2'h2, op);
      check(extended_setup_register_q, op);
      check(partial_array_refresh_q, reg_e[i]);
      check(refresh_bank_keep_q, keep[i]);
      check(drive_strength_q, i[1:0]);
      check(refresh_row_top_zero_q, row0[i]);
    end
    op = 7'h1E;
    ctrl_u.load_ext(2'h2, op);
    check(partial_array_refresh_q, SDCM_PAR_QUARTER);
    check(drive_strength_q, 2'h0);
    ctrl_u.load_ext(2'h0, 7'h21);
    check(burst_count_q, 3'h1);
    check(extended_setup_register_q, op);
    ctrl_u.send(5'h0C, 2'h0, 13'h0000, 1'b0);
    check(deep_powerdown_state_q, 1'b1);
    ctrl_u.send(5'h0F, 2'h0, 13'h0000, 1'b0);
    check(deep_powerdown_state_q, 1'b0);
    check(extended_setup_register_q, op);
    $display("extended mode test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Byte mask gates writing and output drive whatever the command
  task automatic t_mask();
    ctrl_u.send(5'h09, 2'h0, 13'h0000, 1'b1);
    check(write_en_q, 1'b0);
    check(out_drive_en_q, 1'b0);
    ctrl_u.send(5'h0B, 2'h0, 13'h0000, 1'b0);
    check(write_en_q, 1'b1);
    check(out_drive_en_q, 1'b1);
    $display("mask test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog well beyond the roughly 150 cycles the tests need
  initial begin
    #20000;
    bad_count++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_decode();
    t_fields();
    t_std_mode();
    t_ext_mode();
    t_mask();
    test_done();
  end
endmodule
